// ### hw/bclr_down_timer.v
// Sixteen-bit loadable down counter that holds at zero
module bclr_down_timer (
   input wire clk,          // System clock
   input wire reset,        // Synchronous reset
   input wire clkEn,        // Clock enable
   input wire load,         // Load strobe
   input wire [15:0] value, // Load value
   input wire run,          // Counting allowed
   input wire tick,         // Decrement pulse
   output reg [15:0] count  // Present count
);
   always @(posedge clk) begin
      if (reset) begin
         count <= 16'h0000;
      end else if (clkEn) begin
         if (load) begin
            count <= value;
         end else if (run && tick && (count != 16'h0000)) begin
            count <= count - 16'h0001;
         end
      end
   end
endmodule

// ### hw/bclr_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef BCLR_MAP_VH
`define BCLR_MAP_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define BCLR_OFS_LIST_BASE 16'h0033
`define BCLR_OFS_LIST_PTR 16'h0034
`define BCLR_OFS_FRAME_TIME 16'h0035
`define BCLR_OFS_NEXT_MSG 16'h0036
`define BCLR_OFS_COND_CODE 16'h0037
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define BCLR_CC_RUN_BIT 15
`define BCLR_CC_RETRY_HI 14
`define BCLR_CC_RETRY_LO 13
`define BCLR_CC_MESSAGE_FAILED_FLAG_BIT 12
`define BCLR_CC_RESULT_HI 11
`define BCLR_CC_RESULT_LO 8
`define BCLR_CFG_GO_BIT 13
`define BCLR_CFG_ENABLE_BIT 12
`define BCLR_RESET_VALUE 16'h0000
`define BCLR_FLAG_MODE_SET 2'h1
`define BCLR_FLAG_MODE_CLEAR 2'h2
`define BCLR_FLAG_MODE_TOGGLE 2'h3
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BCLR_CLK_HZ 50000000
`define BCLR_FRAME_TICK_US 100
`define BCLR_MSG_TICK_US 1
`define BCLR_FRAME_TICK_CYC (`BCLR_CLK_HZ / 1000000 * `BCLR_FRAME_TICK_US)
`define BCLR_MSG_TICK_CYC (`BCLR_CLK_HZ / 1000000 * `BCLR_MSG_TICK_US)
`endif

// ### hw/bclr_regs.v
// Bus controller instruction list and condition code register bank
`include "bclr_map.vh"

module bclr_regs (
   input wire clk,                   // System clock
   input wire reset,                 // Synchronous master reset
   input wire clkEn,                 // Clock enable
   input wire [15:0] hostAddr,       // Register address
   input wire [15:0] hostWrData,     // Write data
   input wire hostWrite,             // Write strobe
   input wire hostRead,              // Read strobe
   output reg [15:0] hostRdData,     // Read data
   output wire hostRdValid,          // Read data valid
   input wire [15:0] masterConfig,   // Master configuration register value
   input wire controllerEnablePin,   // Enable pin from outside
   input wire opDone,                // Opcode and outcome evaluation finished
   input wire loadFrameTimerOp,      // Load frame timer opcode executes
   input wire startFrameTimerOp,     // Start frame timer opcode executes
   input wire [15:0] opParam,        // Parameter word of executing opcode
   input wire flagUpdateOp,          // Flag opcode executes
   input wire [1:0] flagOpMode,      // Flag opcode mode
   input wire [7:0] flagOpMask,      // Flag opcode bit mask
   input wire compareFrameTimerOp,   // Compare to frame timer executes
   input wire compareMessageTimerOp, // Compare to message timer executes
   input wire [15:0] compareValue,   // Compare opcode reference value
   input wire haltOp,                // Halt opcode executes
   input wire illegalOp,             // Illegal opcode executes
   input wire midSyncCross,          // Mid-sync zero crossing of a message
   input wire [15:0] blockWord4,     // Word four of message block
   input wire msgDone,               // Message finished, results valid
   input wire [1:0] msgRetries,      // Retry count of last message
   input wire msgError,              // Last message error
   input wire msgNoResponse,         // Last message no response
   input wire [3:0] msgResultBits,   // Other last message result bits
   output reg [15:0] listPointer,    // Instruction list pointer
   output wire controllerRunning,    // Controller running status
   output reg illegalOpcodeInterrupt,// Trap interrupt pulse
   output wire [15:0] frameTime,     // Frame time remaining
   output wire [15:0] nextMsgTime    // Time to next message
);
   // ------------------------------------------------------------
   // Pin synchroniser and register state
   // ------------------------------------------------------------
   reg [2:0] enSync_reg;
   reg enPinStable_reg;
   reg [15:0] listBase_reg;
   reg [15:0] condCode_reg;
   reg [15:0] condCode_next;
   reg frameRun_reg;
   reg goPrev_reg;
   wire frameTick;
   wire msgTick;
   wire frameHostLoad;
   wire frameLoad;
   wire [15:0] frameLoadValue;
   wire goRise;
   wire enableOk;
   wire wrListBase;
   wire wrFlagReg;
   wire ptrStep;
   wire runClear;
   wire runSet;

   function [7:0] flagApply;
      input [7:0] cur;
      input [1:0] mode;
      input [7:0] mask;
      begin
         case (mode)
            `BCLR_FLAG_MODE_SET: flagApply = cur | mask;
            `BCLR_FLAG_MODE_CLEAR: flagApply = cur & ~mask;
            `BCLR_FLAG_MODE_TOGGLE: flagApply = cur ^ mask;
            default: flagApply = cur;
         endcase
      end
   endfunction

   function addrHit;
      input [15:0] addr;
      input [15:0] ofs;
      begin
         addrHit = (addr == ofs);
      end
   endfunction

   // Enable pin is asynchronous: accepted once the last two stages agree
   always @(posedge clk) begin
      if (reset) begin
         enSync_reg <= 3'h0;
         enPinStable_reg <= 1'b0;
      end else if (clkEn) begin
         enSync_reg <= {enSync_reg[1:0], controllerEnablePin};
         if (enSync_reg[2] == enSync_reg[1]) begin
            enPinStable_reg <= enSync_reg[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Host write decode
   // ------------------------------------------------------------
   // Writes to the pointer and message timer addresses are ignored
   // Base register write
   assign wrListBase = hostWrite && addrHit(hostAddr, `BCLR_OFS_LIST_BASE);
   assign wrFlagReg = hostWrite && addrHit(hostAddr, `BCLR_OFS_COND_CODE);

   // ------------------------------------------------------------
   // Timebases and timers
   // ------------------------------------------------------------
   // Frame and message timebases, free running from reset
   bclr_tick_gen #(.PERIOD(`BCLR_FRAME_TICK_CYC)) frameTickGen (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .tick(frameTick)
   );

   bclr_tick_gen #(.PERIOD(`BCLR_MSG_TICK_CYC)) msgTickGen (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .tick(msgTick)
   );

   // ------------------------------------------------------------
   // Frame timer
   // ------------------------------------------------------------
   // Ticks run free, so the first decrement lands within one period
   assign frameHostLoad = hostWrite && addrHit(hostAddr, `BCLR_OFS_FRAME_TIME);
   assign frameLoad = loadFrameTimerOp || frameHostLoad;
   assign frameLoadValue = loadFrameTimerOp ? opParam : hostWrData;

   bclr_down_timer frameTimer (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .load(frameLoad),
      .value(frameLoadValue),
      .run(frameRun_reg),
      .tick(frameTick),
      .count(frameTime)
   );

   // Reload takes priority over a tick in the same cycle
   // Per-message load
   bclr_down_timer msgTimer (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .load(midSyncCross),
      .value(blockWord4),
      .run(1'b1),
      .tick(msgTick),
      .count(nextMsgTime)
   );

   // ------------------------------------------------------------
   // Frame count control
   // ------------------------------------------------------------
   // A load opcode stops counting until the next start opcode; a host write reload does not
   // Start frame count
   always @(posedge clk) begin
      if (reset) begin
         frameRun_reg <= 1'b0;
      end else if (clkEn) begin
         if (startFrameTimerOp) begin
            frameRun_reg <= 1'b1;
         end else if (loadFrameTimerOp) begin
            frameRun_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Start, run status and pointer
   // ------------------------------------------------------------
   assign enableOk = enPinStable_reg && masterConfig[`BCLR_CFG_ENABLE_BIT];
   assign goRise = masterConfig[`BCLR_CFG_GO_BIT] && !goPrev_reg && enableOk;
   assign controllerRunning = condCode_reg[`BCLR_CC_RUN_BIT];

   assign ptrStep = opDone && controllerRunning;

   // Go history; a go level left high never restarts the list
   always @(posedge clk) begin
      if (reset) begin
         goPrev_reg <= 1'b0;
      end else if (clkEn) begin
         goPrev_reg <= masterConfig[`BCLR_CFG_GO_BIT];
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         listBase_reg <= `BCLR_RESET_VALUE;
      end else if (clkEn && wrListBase) begin
         listBase_reg <= hostWrData;
      end
   end

   // Pointer holds while stopped and after a halt
   always @(posedge clk) begin
      if (reset) begin
         listPointer <= `BCLR_RESET_VALUE;
      end else if (clkEn) begin
         if (goRise) begin
            listPointer <= listBase_reg;
         end else if (ptrStep) begin
            listPointer <= listPointer + 16'h0002;
         end
      end
   end

   // ------------------------------------------------------------
   // Trap pulse
   // ------------------------------------------------------------
   // Trap pulse
   always @(posedge clk) begin
      if (reset) begin
         illegalOpcodeInterrupt <= 1'b0;
      end else if (clkEn) begin
         illegalOpcodeInterrupt <= illegalOp;
      end
   end

   // ------------------------------------------------------------
   // Condition codes
   // ------------------------------------------------------------
   // Run clear causes
   assign runClear = !enableOk || haltOp || illegalOp;
   assign runSet = goRise;

   // Later sources win: host flags, then flag opcode, then compares
   always @* begin
      condCode_next = condCode_reg;
      // Clear wins over a simultaneous go
      if (runClear) begin
         condCode_next[`BCLR_CC_RUN_BIT] = 1'b0;
      end else if (runSet) begin
         condCode_next[`BCLR_CC_RUN_BIT] = 1'b1;
      end
      // Results change only when a message finishes
      // Message results
      if (msgDone) begin
         condCode_next[`BCLR_CC_RETRY_HI:`BCLR_CC_RETRY_LO] = msgRetries;
         condCode_next[`BCLR_CC_MESSAGE_FAILED_FLAG_BIT] = msgError || msgNoResponse;
         condCode_next[`BCLR_CC_RESULT_HI:`BCLR_CC_RESULT_LO] = msgResultBits;
      end
      if (wrFlagReg) begin
         condCode_next[7:0] = flagApply(condCode_next[7:0], hostWrData[9:8],
                                        hostWrData[7:0]);
      end
      if (flagUpdateOp) begin
         condCode_next[7:0] = flagApply(condCode_next[7:0], flagOpMode, flagOpMask);
      end
      // Bit one means timer below value, bit zero means equal
      // Compare opcodes
      if (compareFrameTimerOp) begin
         condCode_next[1] = frameTime < compareValue;
         condCode_next[0] = frameTime == compareValue;
      end else if (compareMessageTimerOp) begin
         condCode_next[1] = nextMsgTime < compareValue;
         condCode_next[0] = nextMsgTime == compareValue;
      end
   end

   // Status bits change by hardware events, host flag writes to bits 7:0, and reset
   // Reset clear
   always @(posedge clk) begin
      if (reset) begin
         condCode_reg <= `BCLR_RESET_VALUE;
      end else if (clkEn) begin
         condCode_reg <= condCode_next;
      end
   end

   // ------------------------------------------------------------
   // Host read path
   // ------------------------------------------------------------
   reg rdValid_reg;
   reg [15:0] rdData_next;
   assign hostRdValid = rdValid_reg;

   // Condition codes read back here
   // Unmapped addresses read as zero
   always @* begin
      case (hostAddr)
         `BCLR_OFS_LIST_BASE: rdData_next = listBase_reg;
         `BCLR_OFS_LIST_PTR: rdData_next = listPointer;
         `BCLR_OFS_FRAME_TIME: rdData_next = frameTime;
         `BCLR_OFS_NEXT_MSG: rdData_next = nextMsgTime;
         `BCLR_OFS_COND_CODE: rdData_next = condCode_reg;
         default: rdData_next = 16'h0000;
      endcase
   end

   // Read data stands until the next read
   always @(posedge clk) begin
      if (reset) begin
         hostRdData <= 16'h0000;
         rdValid_reg <= 1'b0;
      end else if (clkEn) begin
         rdValid_reg <= hostRead;
         if (hostRead) begin
            hostRdData <= rdData_next;
         end
      end
   end
endmodule

// ### hw/bclr_tick_gen.v
// Free-running tick generator producing a one-cycle pulse every PERIOD cycles
module bclr_tick_gen #(
   parameter PERIOD = 50
) (
   input wire clk,       // System clock
   input wire reset,     // Synchronous reset
   input wire clkEn,     // Clock enable
   output wire tick      // One-cycle pulse
);
   reg [12:0] count_reg;
   assign tick = clkEn && (count_reg == PERIOD - 1);
   always @(posedge clk) begin
      if (reset) begin
         count_reg <= 13'h0000;
      end else if (clkEn) begin
         if (tick) begin
            count_reg <= 13'h0000;
         end else begin
            count_reg <= count_reg + 13'h0001;
         end
      end
   end
endmodule

// ### verif/bclr_host.sv
// Host processor model for register reads and writes
module bclr_host (
   input wire clk, // Clock
   output logic [15:0] hostAddr, // Address
   output logic [15:0] hostWrData, // Write data
   output logic hostWrite, // Write strobe
   output logic hostRead, // Read strobe
   input wire [15:0] hostRdData, // Read data
   input wire hostRdValid // Read valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {hostAddr, hostWrData, hostWrite, hostRead} = '0;
   task wr(input [15:0] a, input [15:0] d);
      @(negedge clk);
      hostAddr = a;
      hostWrData = d;
      hostWrite = 1'b1;
      @(negedge clk);
      hostWrite = 1'b0;
      hostWrData = ~d;
   endtask
   task rd(input [15:0] a, output [15:0] d, output v);
      @(negedge clk);
      hostAddr = a;
      hostRead = 1'b1;
      @(negedge clk);
      hostRead = 1'b0;
      d = hostRdData;
      v = hostRdValid;
   endtask
endmodule

// ### verif/bclr_regs_chk.sv
// Assertion checker for the instruction list register bank
module bclr_regs_chk (
   input wire clk, // Clock
   input wire reset, // Master reset
   input wire clkEn, // Clock enable
   input wire [15:0] hostAddr, // Address
   input wire hostWrite, // Write strobe
   input wire hostRead, // Read strobe
   input wire hostRdValid, // Read valid
   input wire opDone, // Opcode done
   input wire loadFrameTimerOp, // Frame load
   input wire haltOp, // Halt
   input wire illegalOp, // Illegal opcode
   input wire midSyncCross, // Mid-sync
   input wire [15:0] blockWord4, // Timer load value
   input wire [15:0] listPointer, // Pointer
   input wire controllerRunning, // Running
   input wire illegalOpcodeInterrupt, // Trap
   input wire [15:0] frameTime, // Frame timer
   input wire [15:0] nextMsgTime // Message timer
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_read_answer: assert property (clkEn && hostRead |=> hostRdValid)
      else $error("read not answered");
   a_valid_cause: assert property (hostRdValid && $past(clkEn) |-> $past(hostRead))
      else $error("read valid without read");
   a_trap_raise: assert property (clkEn && illegalOp |=> illegalOpcodeInterrupt)
      else $error("trap not raised");
   a_trap_cause: assert property (illegalOpcodeInterrupt && $past(clkEn)
      |-> $past(illegalOp))
      else $error("trap without illegal opcode");
   a_run_stops: assert property (clkEn && (haltOp || illegalOp) |=> !controllerRunning)
      else $error("running after halt");
   a_msg_load: assert property (clkEn && midSyncCross |=> nextMsgTime == $past(blockWord4))
      else $error("message timer not loaded");
   a_msg_hold: assert property (nextMsgTime == 0 && !midSyncCross |=> nextMsgTime == 0)
      else $error("message timer wrapped");
   a_ptr_step: assert property (clkEn && opDone && controllerRunning
      |=> listPointer == $past(listPointer) + 16'h0002)
      else $error("pointer step wrong");
   a_frame_hold: assert property (frameTime == 0 && !loadFrameTimerOp
      && !(hostWrite && hostAddr == 16'h0035) |=> frameTime == 0)
      else $error("frame timer wrapped");
   a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) reset
      |=> listPointer == 0 && frameTime == 0 && nextMsgTime == 0 && !controllerRunning)
      else $error("reset did not clear");
   cover property ($rose(controllerRunning));
   cover property (illegalOpcodeInterrupt);
   cover property (hostRdValid);
endmodule

bind bclr_regs bclr_regs_chk chk (.clk, .reset, .clkEn, .hostAddr, .hostWrite, .hostRead,
   .hostRdValid, .opDone, .loadFrameTimerOp, .haltOp, .illegalOp, .midSyncCross, .blockWord4,
   .listPointer, .controllerRunning, .illegalOpcodeInterrupt, .frameTime, .nextMsgTime);

// ### verif/bus_controller_list_regs_test.sv
// Self-checking bench for the instruction list register bank
module bus_controller_list_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, clkEn, hostWrite, hostRead, hostRdValid, controllerEnablePin;
   logic msgError, msgNoResponse, controllerRunning, illegalOpcodeInterrupt;
   logic [1:0] flagOpMode, msgRetries;
   logic [3:0] msgResultBits;
   logic [7:0] flagOpMask;
   logic [9:0] ops;
   logic [15:0] hostAddr, hostWrData, hostRdData, masterConfig, opParam, compareValue;
   logic [15:0] blockWord4, listPointer, frameTime, nextMsgTime, a;
   int n_fail = 0, num_checks = 0, i;
   bclr_host host (.clk, .hostAddr, .hostWrData, .hostWrite, .hostRead, .hostRdData,
      .hostRdValid);
   bclr_regs uut (.clk, .reset, .clkEn, .hostAddr, .hostWrData, .hostWrite, .hostRead,
      .hostRdData, .hostRdValid, .masterConfig, .controllerEnablePin, .opDone(ops[0]),
      .loadFrameTimerOp(ops[1]), .startFrameTimerOp(ops[2]), .opParam,
      .flagUpdateOp(ops[3]), .flagOpMode, .flagOpMask, .compareFrameTimerOp(ops[4]),
      .compareMessageTimerOp(ops[5]), .compareValue, .haltOp(ops[6]), .illegalOp(ops[7]),
      .midSyncCross(ops[8]), .blockWord4, .msgDone(ops[9]), .msgRetries, .msgError,
      .msgNoResponse, .msgResultBits, .listPointer, .controllerRunning,
      .illegalOpcodeInterrupt, .frameTime, .nextMsgTime);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task chk(input string n, input [15:0] e, input [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task rdchk(input [15:0] ad, input [15:0] e);
      logic [15:0] d;
      logic v;
      host.rd(ad, d, v);
      chk("read valid", 16'h0001, {15'h0000, v});
      chk($sformatf("register %h", ad), e, d);
   endtask
   task pulse(input int b);
      @(negedge clk);
      ops[b] = 1'b1;
      @(negedge clk);
      ops[b] = 1'b0;
   endtask
   task start;
      masterConfig = 16'h1000;
      @(negedge clk);
      masterConfig = 16'h3000;
      repeat (2) @(negedge clk);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      {reset, clkEn, ops, controllerEnablePin, msgError, msgNoResponse} = 15'h6000;
      {masterConfig, opParam, compareValue, blockWord4} = '0;
      {flagOpMode, flagOpMask, msgRetries, msgResultBits} = '0;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      for (a = 16'h0033; a < 16'h0038; a++) rdchk(a, 16'h0000);
      host.wr(16'h0033, 16'h1234);
      host.wr(16'h0034, 16'h5555);
      host.wr(16'h0036, 16'h5555);
      rdchk(16'h0033, 16'h1234);
      rdchk(16'h0034, 16'h0000);
      rdchk(16'h0036, 16'h0000);
      rdchk(16'h0040, 16'h0000);
      controllerEnablePin = 1'b1;
      repeat (5) @(negedge clk);
      start();
      chk("running", 16'h0001, {15'h0000, controllerRunning});
      chk("pointer", 16'h1234, listPointer);
      pulse(0);
      pulse(0);
      chk("pointer step", 16'h1238, listPointer);
      opParam = 16'h0003;
      pulse(1);
      chk("frame load", 16'h0003, frameTime);
      repeat (6000) @(negedge clk);
      chk("frame idle", 16'h0003, frameTime);
      pulse(2);
      for (i = 0; i < 5100 && frameTime !== 16'h0002; i++) @(negedge clk);
      chk("frame tick", 16'h0002, frameTime);
      if (i >= 5100) finish_test();
      repeat (12000) @(negedge clk);
      chk("frame hold", 16'h0000, frameTime);
      host.wr(16'h0037, 16'h01A5);
      rdchk(16'h0037, 16'h80A5);
      host.wr(16'h0037, 16'h03FF);
      rdchk(16'h0037, 16'h805A);
      host.wr(16'h0037, 16'h020F);
      rdchk(16'h0037, 16'h8050);
      {flagOpMode, flagOpMask} = 10'h103;
      pulse(3);
      rdchk(16'h0037, 16'h8053);
      pulse(4);
      rdchk(16'h0037, 16'h8051);
      compareValue = 16'h0005;
      pulse(5);
      rdchk(16'h0037, 16'h8052);
      blockWord4 = 16'h0064;
      pulse(8);
      chk("message load", 16'h0064, nextMsgTime);
      repeat (50) @(negedge clk);
      chk("message tick", 16'h0063, nextMsgTime);
      blockWord4 = 16'h0010;
      pulse(8);
      chk("message reload", 16'h0010, nextMsgTime);
      {msgRetries, msgError, msgResultBits} = 7'h55;
      pulse(9);
      rdchk(16'h0037, 16'hD552);
      {msgRetries, msgError, msgNoResponse, msgResultBits} = 8'h50;
      pulse(9);
      rdchk(16'h0037, 16'hB052);
      {msgRetries, msgNoResponse} = '0;
      pulse(9);
      rdchk(16'h0037, 16'h8052);
      pulse(6);
      chk("halt", 16'h0000, {15'h0000, controllerRunning});
      pulse(0);
      chk("stopped pointer", 16'h1238, listPointer);
      start();
      chk("restart pointer", 16'h1234, listPointer);
      clkEn = 1'b0;
      pulse(0);
      chk("frozen pointer", 16'h1234, listPointer);
      clkEn = 1'b1;
      pulse(7);
      chk("trap", 16'h0001, {15'h0000, illegalOpcodeInterrupt});
      chk("illegal stop", 16'h0000, {15'h0000, controllerRunning});
      start();
      masterConfig = 16'h2000;
      repeat (2) @(negedge clk);
      chk("bit stop", 16'h0000, {15'h0000, controllerRunning});
      start();
      controllerEnablePin = 1'b0;
      repeat (6) @(negedge clk);
      chk("pin stop", 16'h0000, {15'h0000, controllerRunning});
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      rdchk(16'h0033, 16'h0000);
      rdchk(16'h0037, 16'h0000);
      finish_test();
   end
endmodule
